/* File: verilog/tfsd_top.sv */
// transmit frame and multiframe boundary direction and timing control
// assumes a 100 MHz clock, axi4-lite master, pins from the serial clock domain
//
// The address map and the AXI4-Lite slave port were left to the implementer.
module tfsd_top
  import tfsd_pkg::*;
#(
  parameter int FRAME_BITS  = BITS_PER_FRAME,
  parameter int MFRAME_LEN  = FRAMES_PER_MFRAME
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link pins
  input  wire logic        tx_serial_clock_pin,
  input  wire logic        tx_frame_boundary_pin_i,
  output logic             tx_frame_boundary_pin_o,
  output logic             tx_frame_boundary_pin_oe,
  input  wire logic        tx_multiframe_boundary_pin_i,
  output logic             tx_multiframe_boundary_pin_o,
  output logic             tx_multiframe_boundary_pin_oe,
  // framer side
  output logic             frame_start,
  output logic             multiframe_start,
  output logic             backplane_clock_edge
);

  logic [7:0]  sync_mux_control_ff;
  logic [1:0]  css_ff;
  logic        high_speed_ff;
  logic [2:0]  sclk_sync_ff;
  logic [1:0]  fsync_sync_ff;
  logic [1:0]  superframe_boundary_option_sync_ff;
  logic        superframe_boundary_option_q_ff;
  logic        frame_start_ff;
  logic        mframe_start_ff;
  logic        bp_edge_ff;
  logic [7:0]  bit_cnt_ff;
  logic [4:0]  frm_cnt_ff;
  logic        fdrv_ff;
  logic        mdrv_ff;
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  tfsd_src_t   src;
  logic        system_ctrl;
  logic        sclk_rise;
  logic        do_write;
  logic        nxt_fstart;
  logic        nxt_mstart;
  logic        frame_end;
  logic        mframe_end;

  // clock source decode
  always_comb begin
    case (css_ff)
      CSS_TX_SERIAL: src = TFSD_SRC_TX_SERIAL;
      CSS_INTERNAL:  src = TFSD_SRC_INTERNAL;
      default:       src = TFSD_SRC_RECOVERED;
    endcase
  end

  // direction only honoured with serial clock as source
  assign system_ctrl = sync_mux_control_ff[FRAME_SYNC_SEL_BIT] &&
                       (src == TFSD_SRC_TX_SERIAL);

  // two-flop synchronisers for the boundary pins, three flops for the serial clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sclk_sync_ff  <= 3'h0;
      fsync_sync_ff <= 2'h0;
      superframe_boundary_option_sync_ff <= 2'h0;
    end else begin
      sclk_sync_ff  <= {sclk_sync_ff[1:0], tx_serial_clock_pin};
      fsync_sync_ff <= {fsync_sync_ff[0], tx_frame_boundary_pin_i};
      superframe_boundary_option_sync_ff <= {superframe_boundary_option_sync_ff[0], tx_multiframe_boundary_pin_i};
    end
  end

  assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];

  // multiframe level at last serial clock rise, for edge finding
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      superframe_boundary_option_q_ff <= 1'b0;
    end else if (sclk_rise) begin
      superframe_boundary_option_q_ff <= superframe_boundary_option_sync_ff[1];
    end
  end

  assign frame_end  = (bit_cnt_ff == 8'(FRAME_BITS - 1));
  assign mframe_end = frame_end && (frm_cnt_ff == 5'(MFRAME_LEN - 1));

  // frame start source: pins under system control, counters otherwise
  always_comb begin
    nxt_fstart = 1'b0;
    nxt_mstart = 1'b0;
    if (sclk_rise) begin
      if (system_ctrl) begin
        nxt_fstart = fsync_sync_ff[1];
        nxt_mstart = superframe_boundary_option_sync_ff[1] && !high_speed_ff;
      end else begin
        nxt_fstart = frame_end;
        nxt_mstart = mframe_end;
      end
    end
  end

  // bit and frame counters, realigned by incoming boundaries
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bit_cnt_ff <= 8'h00;
      frm_cnt_ff <= 5'h00;
    end else if (sclk_rise) begin
      if (nxt_fstart) begin
        bit_cnt_ff <= 8'h00;
        if (nxt_mstart || frm_cnt_ff == 5'(MFRAME_LEN - 1)) begin
          frm_cnt_ff <= 5'h00;
        end else begin
          frm_cnt_ff <= frm_cnt_ff + 5'h01;
        end
      end else if (frame_end) begin
        bit_cnt_ff <= 8'h00;
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 8'h01;
      end
    end
  end

  // framer strobes, one cycle each
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      frame_start_ff  <= 1'b0;
      mframe_start_ff <= 1'b0;
      bp_edge_ff      <= 1'b0;
    end else begin
      frame_start_ff  <= nxt_fstart;
      mframe_start_ff <= nxt_mstart;
      bp_edge_ff      <= high_speed_ff && system_ctrl && superframe_boundary_option_sync_ff[1]
                         && !superframe_boundary_option_q_ff && sclk_rise;
    end
  end

  // pin drive: outputs pulse at boundary under chip control
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fdrv_ff <= 1'b0;
      mdrv_ff <= 1'b0;
    end else if (sclk_rise) begin
      fdrv_ff <= !system_ctrl && frame_end;
      mdrv_ff <= !system_ctrl && mframe_end;
    end
  end

  assign tx_frame_boundary_pin_o       = fdrv_ff;
  assign tx_multiframe_boundary_pin_o  = mdrv_ff;
  assign tx_frame_boundary_pin_oe      = !system_ctrl;
  assign tx_multiframe_boundary_pin_oe = !system_ctrl;
  assign frame_start                   = frame_start_ff;
  assign multiframe_start              = mframe_start_ff;
  assign backplane_clock_edge          = bp_edge_ff;

  // axi write address and data capture, either order
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  assign do_write      = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // register updates
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync_mux_control_ff <= SYNC_MUX_RESET;
      css_ff              <= CSS_RESET;
      high_speed_ff       <= 1'b0;
    end else if (do_write && wstrb_ff[0]) begin
      case (awaddr_ff[7:2])
        SYNC_MUX_CONTROL_ADDR[7:2]: sync_mux_control_ff <= wdata_ff[7:0] & SYNC_MUX_WMASK;
        CLOCK_SELECT_ADDR[7:2]: begin
          css_ff        <= wdata_ff[CSS_LSB +: 2];
          high_speed_ff <= wdata_ff[HIGH_SPEED_BIT];
        end
        default: ;
      endcase
    end
  end

  // write response
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= AXI_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (awaddr_ff[7:2] == SYNC_MUX_CONTROL_ADDR[7:2] ||
                    awaddr_ff[7:2] == CLOCK_SELECT_ADDR[7:2]) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // read channel
  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= AXI_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= AXI_OKAY;
      case (s_axi_araddr[7:2])
        SYNC_MUX_CONTROL_ADDR[7:2]: rdata_ff <= {24'h000000, sync_mux_control_ff};
        CLOCK_SELECT_ADDR[7:2]: rdata_ff <= {29'h0, high_speed_ff, css_ff};
        FRAMER_STATUS_ADDR[7:2]: rdata_ff <= {16'h0000, 3'h0, frm_cnt_ff,
                                              bit_cnt_ff[7:1], system_ctrl};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

endmodule : tfsd_top

/* File: inc/tfsd_pkg.sv */
// package for the transmit frame boundary direction block
// assumes an axi4-lite master with 32-bit data; registers one word each
package tfsd_pkg;
  // register byte addresses
  localparam logic [7:0] SYNC_MUX_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] CLOCK_SELECT_ADDR     = 8'h04;
  localparam logic [7:0] FRAMER_STATUS_ADDR    = 8'h08;
  // sync mux control fields
  localparam int          FRAME_SYNC_SEL_BIT   = 4;
  localparam int          MFRAME_ALIGN_BIT     = 6;
  localparam int          SUPERFRAME_OPT_BIT   = 5;
  localparam logic [7:0]  SYNC_MUX_RESET       = 8'h00;
  localparam logic [7:0]  SYNC_MUX_WMASK       = 8'h73;
  // clock select fields
  localparam int          CSS_LSB              = 0;
  localparam logic [1:0]  CSS_RESET            = 2'h0;
  localparam logic [1:0]  CSS_RECOVERED_A      = 2'h0;
  localparam logic [1:0]  CSS_TX_SERIAL        = 2'h1;
  localparam logic [1:0]  CSS_INTERNAL         = 2'h2;
  localparam logic [1:0]  CSS_RECOVERED_B      = 2'h3;
  localparam int          HIGH_SPEED_BIT       = 2;
  // frame geometry defaults
  localparam int          BITS_PER_FRAME       = 193;
  localparam int          FRAMES_PER_MFRAME    = 24;
  // axi responses
  localparam logic [1:0]  AXI_OKAY             = 2'h0;
  localparam logic [1:0]  AXI_SLVERR           = 2'h2;

  typedef enum { TFSD_SRC_RECOVERED, TFSD_SRC_TX_SERIAL, TFSD_SRC_INTERNAL } tfsd_src_t;

  // boundary pin drive pair
  typedef struct packed {
    logic o;
    logic oe;
  } tfsd_pin_drv_t;
endpackage : tfsd_pkg

/* File: tb/tfsd_sys_model.sv */
// system-side terminal equipment: serial clock and boundary levels
// assumes the bench asks for serial clock bursts through run
module tfsd_sys_model (
  input wire logic run,
  input wire logic fb,
  input wire logic mfb,
  input wire logic f_o,
  input wire logic f_oe,
  input wire logic m_o,
  input wire logic m_oe,
  output logic     sclk,
  output logic     f_in,
  output logic     m_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fv;
  logic mv;
  // clock stands low between bursts; levels move only while it is low
  initial begin
    sclk = 1'b0;
    fv = 1'b0;
    mv = 1'b0;
    #1;
    forever begin
      #62.5;
      sclk = run & ~sclk;
      if (!sclk) begin
        fv = fb;
        mv = mfb;
      end
    end
  end
  // device enable wins the wire, otherwise the model drives it
  assign f_in = f_oe ? f_o : fv;
  assign m_in = m_oe ? m_o : mv;
endmodule : tfsd_sys_model

/* File: tb/tfsd_chk.sv */
// checker for boundary pin direction and start pulses
// assumes binding onto tfsd_top by port name
module tfsd_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic tx_serial_clock_pin,
  input wire logic tx_frame_boundary_pin_i,
  input wire logic tx_frame_boundary_pin_o,
  input wire logic tx_frame_boundary_pin_oe,
  input wire logic tx_multiframe_boundary_pin_i,
  input wire logic tx_multiframe_boundary_pin_oe,
  input wire logic frame_start,
  input wire logic multiframe_start,
  input wire logic backplane_clock_edge
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // pin direction and reset state
  a_oe_pair: assert property (tx_frame_boundary_pin_oe == tx_multiframe_boundary_pin_oe)
    else $error("pin enables differ");
  a_rst_drive: assert property ($rose(reset_n) |-> tx_frame_boundary_pin_oe &&
    !tx_frame_boundary_pin_o) else $error("pins not driven after reset");
  // start pulses tied to a sampled high input, frame start also to a high serial clock level
  a_fs_cause: assert property (frame_start && !tx_frame_boundary_pin_oe |->
    $past(tx_serial_clock_pin, 2) && $past(tx_frame_boundary_pin_i, 2)) else $error("bad frame");
  a_fs_pulse: assert property (frame_start |=> !frame_start)
    else $error("frame start too long");
  a_mf_cause: assert property (multiframe_start && !tx_multiframe_boundary_pin_oe |->
    $past(tx_multiframe_boundary_pin_i, 2)) else $error("bad multiframe");
  a_mf_pulse: assert property (multiframe_start |=> !multiframe_start)
    else $error("multiframe start too long");
  a_bp_excl: assert property (backplane_clock_edge |-> !multiframe_start)
    else $error("clock edge with multiframe start");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  // main scenarios
  c_fs: cover property (frame_start && !tx_frame_boundary_pin_oe);
  c_mf: cover property (multiframe_start);
  c_bp: cover property (backplane_clock_edge);
endmodule : tfsd_chk

bind tfsd_top tfsd_chk chk (.*);

/* File: tb/tb_tfsd_top.sv */
// self-checking bench for tfsd_top
// assumes tfsd_sys_model on the link pins
module tb_tfsd_top
  import tfsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } tfsd_row_t;
  logic        clock, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, tx_serial_clock_pin, tx_frame_boundary_pin_i, frame_start;
  logic        tx_frame_boundary_pin_o, tx_frame_boundary_pin_oe, tx_multiframe_boundary_pin_i;
  logic        tx_multiframe_boundary_pin_o, tx_multiframe_boundary_pin_oe, multiframe_start;
  logic        backplane_clock_edge, run, fb, mfb, po, pm;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          bad_count, cmp_count, cyc, nf, nm, nb, no, nmo;
  tfsd_row_t   rows [5] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0, AXI_OKAY},
    '{1'b0, 8'h08, 32'h0, 32'h0, AXI_OKAY},
    '{1'b1, 8'h00, 32'hFF, 32'h73, AXI_OKAY},
    '{1'b1, 8'h04, 32'h7, 32'h7, AXI_OKAY},
    '{1'b1, 8'h0C, 32'h1, 32'h0, AXI_SLVERR}};

  tfsd_top #(.FRAME_BITS(8), .MFRAME_LEN(2)) dut (.*);
  tfsd_sys_model sys (.run(run), .fb(fb), .mfb(mfb), .f_o(tx_frame_boundary_pin_o),
    .f_oe(tx_frame_boundary_pin_oe), .m_o(tx_multiframe_boundary_pin_o),
    .m_oe(tx_multiframe_boundary_pin_oe), .sclk(tx_serial_clock_pin),
    .f_in(tx_frame_boundary_pin_i), .m_in(tx_multiframe_boundary_pin_i));

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, bv;
    bv = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (bv !== 1'b1) begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      bv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, rv;
    rv = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (rv !== 1'b1) begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : rd

  // serial clock burst with boundary levels held for n rises
  task automatic burst(input logic f, input logic m, input int n);
    nf = 0;
    nm = 0;
    nb = 0;
    fb <= f;
    mfb <= m;
    repeat (10) @(posedge clock);
    run <= 1'b1;
    repeat (n) @(posedge tx_serial_clock_pin);
    @(posedge clock);
    fb <= 1'b0;
    mfb <= 1'b0;
    repeat (2) @(posedge tx_serial_clock_pin);
    @(posedge clock);
    run <= 1'b0;
    repeat (20) @(posedge clock);
  endtask : burst

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // pulse counters and the hang limit
  always @(posedge clock) begin
    cyc++;
    if (frame_start === 1'b1) nf++;
    if (multiframe_start === 1'b1) nm++;
    if (backplane_clock_edge === 1'b1) nb++;
    if (tx_frame_boundary_pin_o === 1'b1 && po !== 1'b1) no++;
    po = tx_frame_boundary_pin_o;
    if (tx_multiframe_boundary_pin_o === 1'b1 && pm !== 1'b1) nmo++;
    pm = tx_multiframe_boundary_pin_o;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {run, fb, mfb} = 3'h0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, resp);
      if (rows[i].w) chk(32'(resp), 32'(rows[i].r));
      rd(rows[i].a, data, resp);
      chk(data, rows[i].e);
      chk(32'(resp), 32'(rows[i].r));
    end
    $display("register rows done");
    wr(8'h00, 32'h10, resp);
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 32'(c), resp);
      chk(32'(tx_frame_boundary_pin_oe), 32'(c != 1));
      chk(32'(tx_multiframe_boundary_pin_oe), 32'(c != 1));
    end
    wr(8'h04, 32'h1, resp);
    burst(1'b1, 1'b0, 3);
    chk(32'(nf), 32'h3);
    chk(32'(nm), 32'h0);
    burst(1'b0, 1'b1, 2);
    chk(32'(nm), 32'h2);
    chk(32'(nf), 32'h0);
    $display("system side done");
    wr(8'h04, 32'h5, resp);
    burst(1'b0, 1'b1, 3);
    chk(32'(nm), 32'h0);
    chk(32'(nb != 0), 32'h1);
    wr(8'h04, 32'h1, resp);
    wr(8'h00, 32'h0, resp);
    chk(32'(tx_frame_boundary_pin_oe), 32'h1);
    no = 0;
    nmo = 0;
    burst(1'b1, 1'b1, 20);
    chk(32'(no >= 2), 32'h1);
    chk(32'(nmo >= 1), 32'h1);
    chk(32'(nf >= 2), 32'h1);
    chk(32'(nm >= 1), 32'h1);
    $display("chip side done");
    wr(8'h00, 32'h10, resp);
    chk(32'(tx_frame_boundary_pin_oe), 32'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk(32'(tx_frame_boundary_pin_oe), 32'h1);
    chk(32'(tx_multiframe_boundary_pin_oe), 32'h1);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(8'h00, data, resp);
    chk(data, 32'h0);
    rd(8'h04, data, resp);
    chk(data, 32'h0);
    $display("mid-run reset done");
    s_axi_wstrb <= 4'h0;
    wr(8'h00, 32'hFF, resp);
    chk(32'(resp), 32'(AXI_OKAY));
    s_axi_wstrb <= 4'hF;
    rd(8'h00, data, resp);
    chk(data, 32'h0);
    $display("strobe case done");
    results();
  end
endmodule : tb_tfsd_top
